// ---- hw/rsd_lock_vote.sv ----
// three-deep lock history with majority vote
`timescale 1ns/10ps
`default_nettype none
module rsd_lock_vote (
    // clock and reset
    input  wire logic i_sys_clk,
    input  wire logic i_arst_n,
    // measurement input
    input  wire logic i_restart,
    input  wire logic i_meas_valid,
    input  wire logic i_meas_ok,
    // vote result
    output logic      o_locked
);
    logic [2:0] hist_reg;   // newest measurement in bit 0
    logic [2:0] hist_next;

    // two of three
    function automatic logic rsd_maj(input logic [2:0] h);
        return (h[0] & h[1]) | (h[1] & h[2]) | (h[0] & h[2]);
    endfunction

    assign hist_next = {hist_reg[1:0], i_meas_ok};

    // history and vote; a fresh lock needs the two newest both good
    always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            hist_reg <= 3'h0;
            o_locked <= 1'b0;
        end else if (i_restart) begin
            hist_reg <= 3'h0;
            o_locked <= 1'b0;
        end else if (i_meas_valid) begin
            hist_reg <= hist_next;
            if (o_locked) begin
                o_locked <= rsd_maj(hist_next);
            end else begin
                o_locked <= hist_next[0] & hist_next[1];
            end
        end
    end

    property p_vote_rise;
        @(posedge i_sys_clk) disable iff (!i_arst_n)
        $rose(o_locked) |-> (hist_reg[1:0] == 2'b11);
    endproperty
    a_vote_rise: assert property (p_vote_rise)
        else $error("lock rose without two good measurements");

    property p_vote_hold;
        @(posedge i_sys_clk) disable iff (!i_arst_n)
        o_locked |-> rsd_maj(hist_reg);
    endproperty
    a_vote_hold: assert property (p_vote_hold)
        else $error("lock held against the majority");

    property p_vote_restart;
        @(posedge i_sys_clk) disable iff (!i_arst_n)
        i_restart |=> (!o_locked && hist_reg == 3'h0);
    endproperty
    a_vote_restart: assert property (p_vote_restart)
        else $error("history not cleared on restart");
endmodule // rsd_lock_vote
`default_nettype wire

// ---- hw/rsd_pin_sync.sv ----
// three-stage pin synchroniser with rising-edge detect
`timescale 1ns/10ps
`default_nettype none
module rsd_pin_sync (
    // clock and reset
    input  wire logic       i_sys_clk,
    input  wire logic       i_arst_n,
    // raw pins
    input  wire logic [3:0] i_pin,
    // filtered level and one-cycle rising pulse
    output logic      [3:0] o_level,
    output logic      [3:0] o_rise
);
    logic [3:0] s1_reg;     // first stage, read only by s2
    logic [3:0] s2_reg;
    logic [3:0] s3_reg;

    // shift chain
    always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            s1_reg <= 4'h0;
            s2_reg <= 4'h0;
            s3_reg <= 4'h0;
        end else begin
            s1_reg <= i_pin;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
        end
    end

    // a change counts only once stages two and three agree
    always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_level <= 4'h0;
            o_rise  <= 4'h0;
        end else begin
            o_rise  <= s2_reg & s3_reg & ~o_level;
            o_level <= (s2_reg & s3_reg) | (o_level & (s2_reg | s3_reg));
        end
    end
endmodule // rsd_pin_sync
`default_nettype wire

// ---- hw/rsd_pkg.sv ----
// types shared by the synthesiser control block
package rsd_pkg;
    // phase-frequency comparator state
    typedef enum logic [1:0] {
        RSD_PFD_IDLE = 2'b00,
        RSD_PFD_UP   = 2'b01,
        RSD_PFD_DN   = 2'b10
    } rsd_pfd_t;
    typedef logic [19:0] rsd_ndiv_t;
    typedef logic [12:0] rsd_rdiv_t;
endpackage

// ---- hw/rsd_synth_regs.svh ----
// register offsets, field positions, reset values and counts of the synthesiser control block
`ifndef RSD_SYNTH_REGS_SVH
`define RSD_SYNTH_REGS_SVH

// register offsets on the serial control port
`define RSD_ADDR_DATA     8'hb2
`define RSD_ADDR_CTRL     8'hb3
`define RSD_ADDR_STAT     8'hb4

// divider widths
`define RSD_N_W           20
`define RSD_R_W           13

// control register: one byte per channel, channel 1 starts at this bit
`define RSD_CH_STRIDE     8
`define RSD_CB_EN         0
`define RSD_CB_SET        1
`define RSD_CB_TOL        2
`define RSD_CB_GAIN       3
`define RSD_CB_LKIE       4
`define RSD_CB_OLIE       5
`define RSD_CB_REFSEL     6
`define RSD_CTRL_RST      16'h0000

// data register word: target channel, target set, payload
`define RSD_DW_CH         15
`define RSD_DW_SET        14
`define RSD_PAY_W         12
`define RSD_SEQ_N_LO      2'h0
`define RSD_SEQ_N_HI      2'h1
`define RSD_SEQ_R_LO      2'h2
`define RSD_SEQ_R_HI      2'h3

// status register bits
`define RSD_ST_LOCK       0
`define RSD_ST_OOL        2

// divider reset values and lock tolerances in reference cycles
`define RSD_N_RST         20'h0_0001
`define RSD_R_RST         13'h0001
`define RSD_TOL_NARROW    3'h1
`define RSD_TOL_WIDE      3'h4
`define RSD_MEAS_MAX      3'h7

`endif

// ---- hw/rsd_synth_top.sv ----
// two-channel integer-N synthesiser dividers, comparators and lock detect
`timescale 1ns/10ps
`default_nettype none
`include "rsd_synth_regs.svh"

// Notes on behaviour
// - two independent divider sets per channel
// - one control write swaps the active set
// - feedback counter 20 bits, reference 13
// - compare reference/R against VCO/N
// - one reference source for both channels
// - gain bit 3 and bit 11
// - high gain is four times low
// - four data writes build a setup
// - no interlock on active set updates
// - lock tolerance one or four reference cycles
// - majority of last three measurements
// - two good measurements before lock
// - status lock bits, maskable interrupt
// - locked to unlocked raises an event
// - phase lock only, may lag switch
module rsd_synth_top (
    // clock and reset
    input  wire logic        i_sys_clk,
    input  wire logic        i_arst_n,
    // register port
    input  wire logic        i_reg_wr,
    input  wire logic        i_reg_rd,
    input  wire logic [7:0]  i_reg_addr,
    input  wire logic [15:0] i_reg_wdata,
    output logic      [15:0] o_reg_rdata,
    // reference and feedback pins
    input  wire logic        i_xtal_reference,
    input  wire logic        i_synth_reference_clock_input,
    input  wire logic [1:0]  i_vco_feedback,
    // charge pump drive per channel
    output logic      [1:0]  o_charge_pump_output_up,
    output logic      [1:0]  o_charge_pump_output_dn,
    output logic      [1:0]  o_charge_pump_gain_high,
    // host interrupt
    output logic             o_host_irq
);
    //////////////////////////////////////////////////////////////////////////
    // pin synchronisers
    // only the edges clock the dividers, so the filtered levels stay open
    logic [3:0] pin_rise;       // 0 xtal, 1 ref pin, 2..3 vco feedback

    rsd_pin_sync u_sync (
        .i_sys_clk (i_sys_clk),
        .i_arst_n  (i_arst_n),
        .i_pin     ({i_vco_feedback, i_synth_reference_clock_input, i_xtal_reference}),
        .o_level   (),
        .o_rise    (pin_rise)
    );

    //////////////////////////////////////////////////////////////////////////
    // register file
    rsd_pkg::rsd_ndiv_t n_set_reg [2][2];   // [channel][set]
    rsd_pkg::rsd_rdiv_t r_set_reg [2][2];
    logic [15:0]        ctrl_reg;           // write-only channel control
    logic [1:0]         wr_seq_reg;         // position in the four-write setup
    logic [1:0]         ool_reg;            // sticky out-of-lock events
    logic [1:0]         locked;             // vote outputs
    logic [1:0]         locked_prev_reg;
    logic               wr_data;
    logic               wr_ctrl;
    logic               rd_stat;
    logic               dw_ch;
    logic               dw_set;
    logic [`RSD_PAY_W-1:0] dw_pay;

    assign wr_data = i_reg_wr && (i_reg_addr == `RSD_ADDR_DATA);
    assign wr_ctrl = i_reg_wr && (i_reg_addr == `RSD_ADDR_CTRL);
    assign rd_stat = i_reg_rd && (i_reg_addr == `RSD_ADDR_STAT);
    assign dw_ch   = i_reg_wdata[`RSD_DW_CH];
    assign dw_set  = i_reg_wdata[`RSD_DW_SET];
    assign dw_pay  = i_reg_wdata[`RSD_PAY_W-1:0];

    // successive data writes land straight in the addressed set, so partial
    // values are visible until the last word; writing a set that is active
    // is allowed and takes effect at the next terminal count
    always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            wr_seq_reg <= 2'h0;
            for (int c = 0; c < 2; c++) begin
                for (int s = 0; s < 2; s++) begin
                    n_set_reg[c][s] <= `RSD_N_RST;
                    r_set_reg[c][s] <= `RSD_R_RST;
                end
            end
        end else if (wr_ctrl) begin
            wr_seq_reg <= 2'h0;
        end else if (wr_data) begin
            wr_seq_reg <= wr_seq_reg + 2'h1;
            unique case (wr_seq_reg)
                `RSD_SEQ_N_LO: begin
                    n_set_reg[dw_ch][dw_set][`RSD_PAY_W-1:0] <= dw_pay;
                end
                `RSD_SEQ_N_HI: begin
                    n_set_reg[dw_ch][dw_set][`RSD_N_W-1:`RSD_PAY_W] <=
                        dw_pay[`RSD_N_W-`RSD_PAY_W-1:0];
                end
                `RSD_SEQ_R_LO: begin
                    r_set_reg[dw_ch][dw_set][`RSD_PAY_W-1:0] <= dw_pay;
                end
                `RSD_SEQ_R_HI: begin
                    r_set_reg[dw_ch][dw_set][`RSD_R_W-1:`RSD_PAY_W] <=
                        dw_pay[`RSD_R_W-`RSD_PAY_W-1:0];
                end
            endcase
        end
    end

    // channel control: one write flips the set selection of a channel
    always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            ctrl_reg <= `RSD_CTRL_RST;
        end else if (wr_ctrl) begin
            ctrl_reg <= i_reg_wdata;
        end
    end

    // sticky out-of-lock events; a new event beats the read that clears it
    always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            ool_reg         <= 2'h0;
            locked_prev_reg <= 2'h0;
        end else begin
            locked_prev_reg <= locked;
            ool_reg <= (rd_stat ? 2'h0 : ool_reg) | (locked_prev_reg & ~locked);
        end
    end

    // status readback; write-only and unmapped offsets read as zero
    always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_reg_rdata <= 16'h0000;
        end else if (rd_stat) begin
            o_reg_rdata <= {12'h000, ool_reg, locked};
        end else if (i_reg_rd) begin
            o_reg_rdata <= 16'h0000;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // shared reference selection
    logic ref_rise;     // one pulse per undivided reference cycle

    // the xtal or the dedicated pin, picked once for both channels
    assign ref_rise = ctrl_reg[`RSD_CB_REFSEL] ? pin_rise[1] : pin_rise[0];

    // counter reload value, zero programmed is treated as divide by one
    function automatic logic [19:0] rsd_reload(input logic [19:0] v);
        return (v == 20'h0_0000) ? 20'h0_0000 : v - 20'h0_0001;
    endfunction

    //////////////////////////////////////////////////////////////////////////
    // per-channel dividers, comparator and lock measurement
    logic [1:0] irq_src;

    for (genvar ch = 0; ch < 2; ch++) begin : g_ch
        localparam int CB = `RSD_CH_STRIDE * ch;
        rsd_pkg::rsd_ndiv_t n_cnt_reg;      // feedback down counter
        rsd_pkg::rsd_rdiv_t r_cnt_reg;      // reference down counter
        rsd_pkg::rsd_pfd_t  pfd_reg;
        logic [2:0]         meas_reg;       // reference cycles between edges
        logic               meas_valid_reg;
        logic               meas_ok_reg;
        logic               set_prev_reg;
        logic               en;
        logic               sel;
        logic               fb_rise;
        logic               r_tc;
        logic               n_tc;
        logic               restart;
        logic [2:0]         tol;
        logic [2:0]         meas_inc;
        logic [19:0]        r_load;

        assign en       = ctrl_reg[CB + `RSD_CB_EN];
        assign sel      = ctrl_reg[CB + `RSD_CB_SET];
        assign fb_rise  = pin_rise[2 + ch];
        assign r_tc     = en && ref_rise && (r_cnt_reg == 13'h0000);
        assign n_tc     = en && fb_rise && (n_cnt_reg == 20'h0_0000);
        assign tol      = ctrl_reg[CB + `RSD_CB_TOL] ? `RSD_TOL_WIDE : `RSD_TOL_NARROW;
        assign meas_inc = (meas_reg == `RSD_MEAS_MAX) ? meas_reg : meas_reg + 3'h1;
        assign restart  = !en || (sel != set_prev_reg);
        assign r_load   = rsd_reload({7'h00, r_set_reg[ch][sel]});

        // dividers count down and reload from the selected set at terminal
        // count or while disabled, so a swap never truncates a cycle in flight
        always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
            if (!i_arst_n) begin
                r_cnt_reg <= 13'h0000;
                n_cnt_reg <= 20'h0_0000;
            end else if (!en) begin
                r_cnt_reg <= r_load[`RSD_R_W-1:0];
                n_cnt_reg <= rsd_reload(n_set_reg[ch][sel]);
            end else begin
                if (ref_rise) begin
                    r_cnt_reg <= (r_cnt_reg == 13'h0000) ?
                                 r_load[`RSD_R_W-1:0] : r_cnt_reg - 13'h0001;
                end
                if (fb_rise) begin
                    n_cnt_reg <= (n_cnt_reg == 20'h0_0000) ?
                                 rsd_reload(n_set_reg[ch][sel]) :
                                 n_cnt_reg - 20'h0_0001;
                end
            end
        end

        // phase-frequency comparator; the gap between the divided edges
        // is timed in undivided reference cycles, not comparison cycles
        always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
            if (!i_arst_n) begin
                pfd_reg        <= rsd_pkg::RSD_PFD_IDLE;
                meas_reg       <= 3'h0;
                meas_valid_reg <= 1'b0;
                meas_ok_reg    <= 1'b0;
            end else if (!en) begin
                pfd_reg        <= rsd_pkg::RSD_PFD_IDLE;
                meas_reg       <= 3'h0;
                meas_valid_reg <= 1'b0;
                meas_ok_reg    <= 1'b0;
            end else begin
                meas_valid_reg <= 1'b0;
                unique case (pfd_reg)
                    rsd_pkg::RSD_PFD_IDLE: begin
                        meas_reg <= 3'h0;
                        if (r_tc && n_tc) begin
                            meas_valid_reg <= 1'b1;
                            meas_ok_reg    <= 1'b1;
                        end else if (r_tc) begin
                            pfd_reg <= rsd_pkg::RSD_PFD_UP;
                        end else if (n_tc) begin
                            pfd_reg <= rsd_pkg::RSD_PFD_DN;
                        end
                    end
                    rsd_pkg::RSD_PFD_UP: begin
                        if (n_tc) begin
                            pfd_reg        <= rsd_pkg::RSD_PFD_IDLE;
                            meas_valid_reg <= 1'b1;
                            meas_ok_reg    <= (ref_rise ? meas_inc : meas_reg) <= tol;
                        end else if (ref_rise) begin
                            meas_reg <= meas_inc;
                        end
                    end
                    rsd_pkg::RSD_PFD_DN: begin
                        if (r_tc) begin
                            pfd_reg        <= rsd_pkg::RSD_PFD_IDLE;
                            meas_valid_reg <= 1'b1;
                            meas_ok_reg    <= meas_inc <= tol;
                        end else if (ref_rise) begin
                            meas_reg <= meas_inc;
                        end
                    end
                endcase
            end
        end

        // charge pump drive and gain; the analogue stage gives 4:1 current
        always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
            if (!i_arst_n) begin
                o_charge_pump_output_up[ch] <= 1'b0;
                o_charge_pump_output_dn[ch] <= 1'b0;
                o_charge_pump_gain_high[ch] <= 1'b0;
                set_prev_reg                <= 1'b0;
            end else begin
                o_charge_pump_output_up[ch] <= (pfd_reg == rsd_pkg::RSD_PFD_UP);
                o_charge_pump_output_dn[ch] <= (pfd_reg == rsd_pkg::RSD_PFD_DN);
                o_charge_pump_gain_high[ch] <= ctrl_reg[CB + `RSD_CB_GAIN];
                set_prev_reg                <= sel;
            end
        end

        // lock only ever claims phase agreement and may lag a set swap
        rsd_lock_vote u_vote (
            .i_sys_clk    (i_sys_clk),
            .i_arst_n     (i_arst_n),
            .i_restart    (restart),
            .i_meas_valid (meas_valid_reg),
            .i_meas_ok    (meas_ok_reg),
            .o_locked     (locked[ch])
        );

        assign irq_src[ch] = (locked[ch] && ctrl_reg[CB + `RSD_CB_LKIE]) ||
                             (ool_reg[ch] && ctrl_reg[CB + `RSD_CB_OLIE]);

        property p_meas_tol;
            @(posedge i_sys_clk) disable iff (!i_arst_n)
            (en && pfd_reg == rsd_pkg::RSD_PFD_UP && n_tc && !ref_rise
             && meas_reg > tol) |=> (meas_valid_reg && !meas_ok_reg);
        endproperty
        a_meas_tol: assert property (p_meas_tol)
            else $error("late edge judged inside tolerance");

        property p_ref_reload;
            @(posedge i_sys_clk) disable iff (!i_arst_n)
            (r_tc && !wr_data && !wr_ctrl)
            |=> ({7'h00, r_cnt_reg} == rsd_reload({7'h00, r_set_reg[ch][sel]}));
        endproperty
        a_ref_reload: assert property (p_ref_reload)
            else $error("reference counter reloaded with wrong value");

        property p_gain_bit;
            @(posedge i_sys_clk) disable iff (!i_arst_n)
            wr_ctrl |-> ##2
                (o_charge_pump_gain_high[ch] == $past(i_reg_wdata[CB + `RSD_CB_GAIN], 2));
        endproperty
        a_gain_bit: assert property (p_gain_bit)
            else $error("gain output does not follow the control bit");
    end

    // interrupt line, registered
    always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_host_irq <= 1'b0;
        end else begin
            o_host_irq <= |irq_src;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // checks on the shared logic
    property p_set_switch;
        @(posedge i_sys_clk) disable iff (!i_arst_n)
        wr_ctrl |=> (ctrl_reg[`RSD_CB_SET] == $past(i_reg_wdata[`RSD_CB_SET]));
    endproperty
    a_set_switch: assert property (p_set_switch)
        else $error("set selection not taken from control write");

    property p_ool_event;
        @(posedge i_sys_clk) disable iff (!i_arst_n)
        (locked_prev_reg[0] && !locked[0]) |=> ool_reg[0];
    endproperty
    a_ool_event: assert property (p_ool_event)
        else $error("loss of lock not recorded");

    property p_irq_ool;
        @(posedge i_sys_clk) disable iff (!i_arst_n)
        (ool_reg[0] && ctrl_reg[`RSD_CB_OLIE]) |=> o_host_irq;
    endproperty
    a_irq_ool: assert property (p_irq_ool)
        else $error("unmasked event did not raise interrupt");

    property p_data_seq;
        @(posedge i_sys_clk) disable iff (!i_arst_n)
        (wr_data && wr_seq_reg == `RSD_SEQ_N_LO) |=>
            (n_set_reg[$past(dw_ch)][$past(dw_set)][`RSD_PAY_W-1:0] == $past(dw_pay))
            && (wr_seq_reg == `RSD_SEQ_N_HI);
    endproperty
    a_data_seq: assert property (p_data_seq)
        else $error("first data word not stored");
endmodule // rsd_synth_top
`default_nettype wire

// ---- test/rsd_host_model.sv ----
// host controller model that drives the register port of the synthesiser block
`timescale 1ns/10ps
`default_nettype none
module rsd_host_model (
    // clock
    input  wire logic        i_sys_clk,
    // register port towards the device
    output logic             o_reg_wr,
    output logic             o_reg_rd,
    output logic      [7:0]  o_reg_addr,
    output logic      [15:0] o_reg_wdata,
    input  wire logic [15:0] i_reg_rdata
);
    // idle bus carries inverted data so a stale word can never pass for a fresh one
    initial begin
        o_reg_wr = 1'b0;
        o_reg_rd = 1'b0;
        o_reg_addr = 8'h00;
        o_reg_wdata = 16'h0000;
    end
    // one write strobe per word; a setup is four of these in a row
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge i_sys_clk);
        #1;
        o_reg_wr = 1'b1;
        o_reg_addr = a;
        o_reg_wdata = d;
        @(posedge i_sys_clk);
        #1;
        o_reg_wr = 1'b0;
        o_reg_wdata = ~d;
    endtask
    // read strobe, data taken once the taking edge has landed
    task automatic rd(input logic [7:0] a, output logic [15:0] d);
        @(posedge i_sys_clk);
        #1;
        o_reg_rd = 1'b1;
        o_reg_addr = a;
        @(posedge i_sys_clk);
        #1;
        o_reg_rd = 1'b0;
        d = i_reg_rdata;
    endtask
endmodule // rsd_host_model
`default_nettype wire

// ---- test/rsd_synth_top_test.sv ----
// self-checking bench for the two-channel synthesiser control block
`timescale 1ns/10ps
`default_nettype none
`include "rsd_synth_regs.svh"
module rsd_synth_top_test;
    logic        clk = 1'b0;
    logic        arst_n = 1'b0;
    logic        wr, rd, irq, xtal = 1'b0, vco = 1'b0, hold = 1'b0;
    logic [7:0]  addr;
    logic [15:0] wdata, rdata, v;
    logic [1:0]  up, dn, gain;
    logic [3:0]  div = 4'h0;
    int          num_errors = 0;
    int          samples_checked = 0;
    int          up_cnt = 0;
    int          dn_cnt = 0;
    initial forever #10 clk = ~clk;
    // reference period 8 cycles; holding the vco low slips its phase by whole cycles
    // pump cycles of channel 0 are counted so scenarios can judge the comparator
    always @(posedge clk) begin
        div <= div + 4'h1;
        xtal <= div[2];
        vco <= hold ? 1'b0 : div[2];
        up_cnt <= up_cnt + int'(up[0]);
        dn_cnt <= dn_cnt + int'(dn[0]);
    end
    rsd_host_model u_host (.i_sys_clk(clk), .o_reg_wr(wr), .o_reg_rd(rd), .o_reg_addr(addr),
        .o_reg_wdata(wdata), .i_reg_rdata(rdata));
    rsd_synth_top u_dut (.i_sys_clk(clk), .i_arst_n(arst_n), .i_reg_wr(wr), .i_reg_rd(rd),
        .i_reg_addr(addr), .i_reg_wdata(wdata), .o_reg_rdata(rdata),
        .i_xtal_reference(xtal), .i_synth_reference_clock_input(1'b0),
        .i_vco_feedback({1'b0, vco}), .o_charge_pump_output_up(up),
        .o_charge_pump_output_dn(dn), .o_charge_pump_gain_high(gain), .o_host_irq(irq));
    ////////////////////////////////////////////////////////////////////////////
    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic give_verdict();
        $display("checks %0d errors %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task automatic wait_cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    // quiet status after reset, control offset reads back nothing
    task automatic t_reset();
        u_host.rd(`RSD_ADDR_STAT, v);
        check("status", v, 16'h0000);
        u_host.rd(`RSD_ADDR_CTRL, v);
        check("ctrl_rd", v, 16'h0000);
        check("irq", {15'h0000, irq}, 16'h0000);
    endtask
    // gain bits at 3 and 11 drive each channel
    task automatic t_gain();
        u_host.wr(`RSD_ADDR_CTRL, 16'h0909);
        wait_cyc(2);
        check("gain_both", {14'h0000, gain}, 16'h0003);
        u_host.wr(`RSD_ADDR_CTRL, 16'h0029);
        wait_cyc(2);
        check("gain_ch0", {14'h0000, gain}, 16'h0001);
    endtask
    // both sets of channel 0 divide by 32: a 195 kHz step from the 6.25 MHz reference
    task automatic t_program();
        u_host.wr(`RSD_ADDR_CTRL, 16'h0000);
        for (int s = 0; s < 2; s++) begin
            u_host.wr(`RSD_ADDR_DATA, {1'b0, s[0], 14'h0020});
            u_host.wr(`RSD_ADDR_DATA, {1'b0, s[0], 14'h0000});
            u_host.wr(`RSD_ADDR_DATA, {1'b0, s[0], 14'h0020});
            u_host.wr(`RSD_ADDR_DATA, {1'b0, s[0], 14'h0000});
        end
    endtask
    // matched loop locks, a set swap restarts the history, lock returns on set 1
    task automatic t_lock_switch();
        int u0;
        u0 = up_cnt + dn_cnt;
        u_host.wr(`RSD_ADDR_CTRL, 16'h0029);
        wait_cyc(700);
        check("pump_idle", 16'(up_cnt + dn_cnt - u0), 16'h0000);
        u_host.rd(`RSD_ADDR_STAT, v);
        check("lock_set0", v, 16'h0001);
        u_host.wr(`RSD_ADDR_CTRL, 16'h003b);
        wait_cyc(3);
        u_host.rd(`RSD_ADDR_STAT, v);
        check("lock_after_swap", v & 16'h0001, 16'h0000);
        wait_cyc(700);
        u_host.rd(`RSD_ADDR_STAT, v);
        check("lock_set1", v & 16'h0001, 16'h0001);
        u_host.rd(`RSD_ADDR_STAT, v);
        check("status_clean", v, 16'h0001);
        wait_cyc(2);
        check("irq_lock", {15'h0000, irq}, 16'h0001);
    endtask
    // a phase slip of half a comparison period loses lock and leaves a sticky event
    task automatic t_unlock();
        int u0;
        int d0;
        u_host.wr(`RSD_ADDR_CTRL, 16'h002b);
        u0 = up_cnt;
        d0 = dn_cnt;
        hold = 1'b1;
        wait_cyc(128);
        hold = 1'b0;
        wait_cyc(900);
        check("irq_event", {15'h0000, irq}, 16'h0001);
        check("pump_up", {15'h0000, up_cnt > u0}, 16'h0001);
        check("pump_dn", 16'(dn_cnt - d0), 16'h0000);
        u_host.rd(`RSD_ADDR_STAT, v);
        check("unlock", v, 16'h0004);
        u_host.rd(`RSD_ADDR_STAT, v);
        check("event_cleared", v, 16'h0000);
    endtask
    // reference taken from the quiet pin: only feedback edges come, pump stays down
    task automatic t_refsel();
        u_host.wr(`RSD_ADDR_CTRL, 16'h006b);
        wait_cyc(600);
        check("pump_ref_pin", {14'h0000, up[0], dn[0]}, 16'h0001);
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        wait_cyc(12);
        arst_n = 1'b1;
        t_reset();
        t_gain();
        t_program();
        t_lock_switch();
        t_unlock();
        t_refsel();
        give_verdict();
    end
    // the whole run is about 3100 cycles; a hang is cut well beyond that
    initial begin
        #200000;
        num_errors++;
        give_verdict();
    end
endmodule // rsd_synth_top_test
`default_nettype wire
